// ==== verilog/hrs_homing_sequencer.sv ====
`timescale 1ns/10ps
`include "hrs_defs.svh"

module hrs_homing_sequencer
    import hrs_pkg::*;
#(
    parameter logic [31:0] CFG_RESET = `HRS_CFG_RESET
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic homeSwPin,
    input wire logic limPosPin,
    input wire logic limNegPin,
    input wire logic zeroPulsePin,
    input wire logic curThrPin,
    input wire logic absValid,
    input wire logic [15:0] angleMoved,
    output hrs_motion_t motion,
    output logic [31:0] zeroOffset,
    output logic referencedOutput
);
    typedef struct packed {
        hrs_state_t state;
        logic [31:0] cfg;
        logic [31:0] offset;
        logic [15:0] mtWin;
        logic pendHome;
        logic referenced;
        logic absBad;
        logic done;
        logic powerUp;
        logic dirPos;
        logic prevSw;
        logic prevZp;
        logic wrPend;
        logic [11:0] wrAddr;
        logic [31:0] rdata;
        hrs_motion_t mot;
    } hrs_st_t;

    // Power-on configuration stands in for the stored one; its window must be servable
    if (CFG_RESET[`HRS_CFG_DEB_MSB:`HRS_CFG_DEB_LSB] > `HRS_DEB_MAX_MS) begin : badCfgReset
        $error("hrs_homing_sequencer: reset debounce window too long");
    end

    hrs_st_t st_reg;
    hrs_st_t st_next;
    logic [4:0] syncA;
    logic [4:0] syncB;
    hrs_sense_t sense;
    logic homeDeb;
    hrs_mode_t mode;
    logic start;
    logic download;
    logic abort;
    logic endOfTravel;
    logic swEdge;
    logic zpEdge;
    logic found;

    // -----------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 5'h00;
            syncB <= 5'h00;
        end else begin
            syncA <= {homeSwPin, limPosPin, limNegPin, zeroPulsePin, curThrPin};
            syncB <= syncA;
        end
    end

    assign sense = hrs_sense_t'(syncB);

    hrs_debounce u_deb (
        .clk(clk),
        .rstn(rstn),
        .din(sense.homeSw),
        .windowMs(st_reg.cfg[`HRS_CFG_DEB_MSB:`HRS_CFG_DEB_LSB]),
        .dout(homeDeb)
    );

    hrs_mode_decode u_dec (
        .code(st_reg.cfg[`HRS_CFG_MODE_MSB:`HRS_CFG_MODE_LSB]),
        .mode(mode)
    );

    // -----------------------------------------------------------
    // Bus write strobes and sensing helpers
    // -----------------------------------------------------------
    assign start = st_reg.wrPend && st_reg.wrAddr == `HRS_OFF_CTRL &&
                   hwdata[`HRS_CTRL_START];
    assign download = st_reg.wrPend && st_reg.wrAddr == `HRS_OFF_CFG;
    assign abort = st_reg.wrPend && st_reg.wrAddr == `HRS_OFF_CTRL &&
                   hwdata[`HRS_CTRL_ABORT];
    // Current threshold may stand in for reversal switches
    assign endOfTravel = st_reg.cfg[`HRS_CFG_CURTHR] ? sense.curThr :
                         (st_reg.dirPos ? sense.limPos : sense.limNeg);
    assign swEdge = homeDeb != st_reg.prevSw;
    assign zpEdge = sense.zeroPulse && !st_reg.prevZp;
    // Machine-zero event for the active mode
    assign found = (mode.useSwitch && swEdge) ||
                   (mode.useLimit && endOfTravel) ||
                   (mode.useBlock && sense.curThr) ||
                   (!mode.useSwitch && !mode.useLimit && mode.usePulse && zpEdge);

    // -----------------------------------------------------------
    // Sequencer and register file
    // -----------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.prevSw = homeDeb;
        st_next.prevZp = sense.zeroPulse;
        st_next.mot.setZero = 1'b0;
        st_next.done = 1'b0;
        // Address phase capture; single-cycle response, always OKAY
        st_next.wrPend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            st_next.wrPend = hwrite;
            st_next.wrAddr = haddr;
            if (haddr == `HRS_OFF_CTRL) begin
                st_next.rdata = 32'h00000000;
            end else if (haddr == `HRS_OFF_CFG) begin
                st_next.rdata = st_reg.cfg;
            end else if (haddr == `HRS_OFF_STAT) begin
                st_next.rdata = 32'h00000000;
                st_next.rdata[`HRS_STAT_BUSY] = st_reg.state != HRS_IDLE;
                st_next.rdata[`HRS_STAT_NOLIM] = st_reg.mot.limitsOff;
                st_next.rdata[`HRS_STAT_ABSBAD] = st_reg.absBad;
                st_next.rdata[`HRS_STAT_DONE] = st_reg.pendHome;
                st_next.rdata[`HRS_STAT_REF] = st_reg.referenced;
            end else if (haddr == `HRS_OFF_MTWIN) begin
                st_next.rdata = {16'h0000, st_reg.mtWin};
            end else if (haddr == `HRS_OFF_OFFSET) begin
                st_next.rdata = st_reg.offset;
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end
        if (st_reg.wrPend && st_reg.wrAddr == `HRS_OFF_MTWIN) begin
            st_next.mtWin = hwdata[15:0];
        end
        if (st_reg.wrPend && st_reg.wrAddr == `HRS_OFF_OFFSET) begin
            st_next.offset = hwdata;
        end
        // Power-on restore happens once, one cycle after reset release
        if (st_reg.powerUp) begin
            st_next.powerUp = 1'b0;
            if (st_reg.cfg[`HRS_CFG_ABSENC] && absValid) begin
                st_next.referenced = 1'b1;
            end else if (st_reg.cfg[`HRS_CFG_MTEMU]) begin
                // Position is restored either way; flag only if inside window
                st_next.referenced = angleMoved <= st_reg.mtWin;
                st_next.absBad = angleMoved > st_reg.mtWin;
            end
        end
        case (st_reg.state)
            HRS_IDLE: begin
                if (start && mode.valid && (st_reg.pendHome || !st_reg.referenced ||
                    st_reg.cfg[`HRS_CFG_WITHREF])) begin
                    st_next.mot.limitsOff = 1'b1;
                    st_next.pendHome = 1'b0;
                    if (mode.here) begin
                        // No motion, zero taken at present position
                        st_next.mot.setZero = 1'b1;
                        st_next.state = HRS_DONE;
                    end else begin
                        st_next.dirPos = !homeDeb;
                        st_next.mot.run = 1'b1;
                        st_next.mot.dirPos = !homeDeb;
                        st_next.state = HRS_SEEK;
                    end
                end
            end
            HRS_SEEK: begin
                if (mode.useSwitch && endOfTravel) begin
                    // Reverse at travel end and keep searching
                    st_next.dirPos = !st_reg.dirPos;
                    st_next.mot.dirPos = !st_reg.dirPos;
                end else if (found) begin
                    st_next.state = mode.usePulse && (mode.useSwitch || mode.useLimit) ?
                                    HRS_PULSE : HRS_APPROACH;
                    st_next.mot.setZero = !(mode.usePulse &&
                                            (mode.useSwitch || mode.useLimit));
                end
            end
            HRS_PULSE: begin
                if (zpEdge) begin
                    st_next.mot.setZero = 1'b1;
                    st_next.state = HRS_APPROACH;
                end
            end
            HRS_APPROACH: begin
                st_next.mot.run = 1'b0;
                st_next.mot.gotoZero = !st_reg.cfg[`HRS_CFG_NOAPPROACH];
                st_next.state = HRS_DONE;
            end
            HRS_DONE: begin
                st_next.mot.gotoZero = 1'b0;
                st_next.mot.limitsOff = 1'b0;
                st_next.referenced = 1'b1;
                st_next.absBad = 1'b0;
                st_next.done = 1'b1;
                st_next.state = HRS_IDLE;
            end
            default: begin
                st_next.state = HRS_IDLE;
            end
        endcase
        if (abort && st_reg.state != HRS_IDLE) begin
            st_next.mot = '0;
            st_next.state = HRS_IDLE;
        end
        // Download drops the reference and arms homing on next start
        if (download) begin
            st_next.cfg = hwdata;
            st_next.referenced = 1'b0;
            st_next.pendHome = 1'b1;
            st_next.mot = '0;
            st_next.state = HRS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.cfg <= CFG_RESET;
            st_reg.powerUp <= 1'b1;
            st_reg.pendHome <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign motion = st_reg.mot;
    assign zeroOffset = st_reg.offset;
    assign referencedOutput = st_reg.referenced;

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    limitsOff_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg.state == HRS_SEEK || st_reg.state == HRS_PULSE) |-> motion.limitsOff)
        else $error("limits checked during homing");
    dlClear_a: assert property (@(posedge clk) disable iff (!rstn)
        download |=> !referencedOutput && st_reg.pendHome)
        else $error("download kept reference");
    hereNoMove_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg.state == HRS_DONE && $rose(motion.setZero) && !motion.run && mode.here &&
         !download) |=> referencedOutput)
        else $error("mode here did not reference");
    approach_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg.state == HRS_APPROACH && !st_reg.cfg[`HRS_CFG_NOAPPROACH] && !download &&
         !abort) |=> motion.gotoZero)
        else $error("no approach to zero");
    noApproach_a: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.cfg[`HRS_CFG_NOAPPROACH] && st_reg.state == HRS_APPROACH |=> !motion.gotoZero)
        else $error("approach not suppressed");
    pulseWait_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg.state == HRS_PULSE && !zpEdge && !download && !abort) |=>
        st_reg.state == HRS_PULSE)
        else $error("left pulse wait without pulse");
    mtWindow_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg.powerUp && st_reg.cfg[`HRS_CFG_MTEMU] && !st_reg.cfg[`HRS_CFG_ABSENC] &&
         !download && angleMoved > st_reg.mtWin) |=> !referencedOutput && st_reg.absBad)
        else $error("referenced outside validity window");
    doneRef_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg.state == HRS_DONE && !download) |=> referencedOutput && !motion.limitsOff)
        else $error("homing end did not reference");
    startC: cover property (@(posedge clk) disable iff (!rstn)
        st_reg.state == HRS_SEEK ##[1:1000] st_reg.state == HRS_DONE);
    pulseC: cover property (@(posedge clk) disable iff (!rstn) st_reg.state == HRS_PULSE);
    restoreC: cover property (@(posedge clk) disable iff (!rstn)
        st_reg.powerUp ##1 referencedOutput);
endmodule : hrs_homing_sequencer

// ==== include/hrs_defs.svh ====
`ifndef HRS_DEFS_SVH
`define HRS_DEFS_SVH

// AHB-Lite register byte offsets
`define HRS_OFF_CTRL 12'h000
`define HRS_OFF_CFG 12'h004
`define HRS_OFF_STAT 12'h008
`define HRS_OFF_MTWIN 12'h00c
`define HRS_OFF_OFFSET 12'h010

// Control register bits (write one to act; DOWNLOAD is not decoded, a CFG write downloads)
`define HRS_CTRL_START 0
`define HRS_CTRL_DOWNLOAD 1
`define HRS_CTRL_ABORT 2

// Configuration register fields
`define HRS_CFG_MODE_LSB 0
`define HRS_CFG_MODE_MSB 7
`define HRS_CFG_NOAPPROACH 8
`define HRS_CFG_WITHREF 9
`define HRS_CFG_ABSENC 10
`define HRS_CFG_MTEMU 11
`define HRS_CFG_CURTHR 12
`define HRS_CFG_DEB_LSB 16
`define HRS_CFG_DEB_MSB 20
`define HRS_CFG_RESET 32'h0000_0200

// Status register bits
`define HRS_STAT_BUSY 0
`define HRS_STAT_REF 12
`define HRS_STAT_NOLIM 1
`define HRS_STAT_ABSBAD 2
`define HRS_STAT_DONE 3

// Homing mode codes
`define HRS_M_NONE 8'h00
`define HRS_M_Z1 8'h01
`define HRS_M_Z2 8'h02
`define HRS_M_SZ_LO 8'h03
`define HRS_M_SZ_HI 8'h0e
`define HRS_M_LIM_LO 8'h11
`define HRS_M_LIM_HI 8'h12
`define HRS_M_SW_LO 8'h13
`define HRS_M_SW_HI 8'h1e
`define HRS_M_Z33 8'h21
`define HRS_M_Z34 8'h22
`define HRS_M_HERE 8'h23
`define HRS_M_BLK_LO 8'h80
`define HRS_M_BLK_HI 8'h81
`define HRS_M_ZX_LO 8'h82
`define HRS_M_ZX_HI 8'h85

// Debounce sample period
`define HRS_SAMPLE_NS 500000
`define HRS_CLK_NS 5
`define HRS_SAMPLE_CYC (`HRS_SAMPLE_NS / `HRS_CLK_NS)
`define HRS_DEB_MAX_MS 20
`define HRS_SAMPLES_PER_MS 2

`endif

// ==== include/hrs_pkg.sv ====
package hrs_pkg;
    typedef enum logic [2:0] {
        HRS_IDLE = 3'b000,
        HRS_SEEK = 3'b001,
        HRS_PULSE = 3'b011,
        HRS_APPROACH = 3'b010,
        HRS_DONE = 3'b110
    } hrs_state_t;

    typedef enum logic [1:0] {
        HRS_K_NONE = 2'h0,
        HRS_K_SWITCH = 2'h1,
        HRS_K_PULSE = 2'h2,
        HRS_K_BLOCK = 2'h3
    } hrs_kind_t;

    // Decoded homing mode
    typedef struct packed {
        logic valid;
        logic here;
        logic useSwitch;
        logic useLimit;
        logic useBlock;
        logic usePulse;
    } hrs_mode_t;

    // Switch and feedback inputs after synchronising
    typedef struct packed {
        logic homeSw;
        logic limPos;
        logic limNeg;
        logic zeroPulse;
        logic curThr;
    } hrs_sense_t;

    // Motion commands toward the position loop
    typedef struct packed {
        logic run;
        logic dirPos;
        logic gotoZero;
        logic setZero;
        logic limitsOff;
    } hrs_motion_t;
endpackage : hrs_pkg

// ==== verilog/hrs_debounce.sv ====
`timescale 1ns/10ps
`include "hrs_defs.svh"

// Majority-vote debouncer; window of zero passes the level straight on
module hrs_debounce
    import hrs_pkg::*;
#(
    parameter int SAMPLE_CYC = `HRS_SAMPLE_CYC,
    parameter int MAXN = `HRS_DEB_MAX_MS * `HRS_SAMPLES_PER_MS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    input wire logic [4:0] windowMs,
    output logic dout
);
    // The tick counter is 18 bits wide and the sample counters 6 bits
    if (SAMPLE_CYC < 1 || SAMPLE_CYC > (1 << 18) || MAXN < 1 || MAXN > 63) begin : badParams
        $error("hrs_debounce: bad parameters");
    end

    typedef struct packed {
        logic [17:0] tick;
        logic [5:0] cnt;
        logic [5:0] ones;
        logic level;
    } hrs_deb_st_t;

    hrs_deb_st_t st_reg;
    hrs_deb_st_t st_next;
    logic [5:0] nSamp;

    // -----------------------------------------------------------
    // Vote logic
    // -----------------------------------------------------------
    // Counts ones in each window; with a nonzero window, level flips only on a strict majority
    always_comb begin
        st_next = st_reg;
        nSamp = 6'(windowMs) <<< 1;
        if (nSamp > 6'(MAXN)) begin
            nSamp = 6'(MAXN);
        end
        if (windowMs == 5'h00) begin
            st_next.level = din;
            st_next.cnt = 6'h00;
            st_next.ones = 6'h00;
        end else if (st_reg.tick == 18'(SAMPLE_CYC - 1)) begin
            st_next.tick = 18'h00000;
            if (st_reg.cnt + 6'h01 >= nSamp) begin
                // Strict majority over the whole window
                if ((7'(st_reg.ones) + 7'(din)) * 7'h02 > 7'(nSamp)) begin
                    st_next.level = 1'b1;
                end else if ((7'(st_reg.ones) + 7'(din)) * 7'h02 < 7'(nSamp)) begin
                    st_next.level = 1'b0;
                end
                st_next.cnt = 6'h00;
                st_next.ones = 6'h00;
            end else begin
                st_next.cnt = st_reg.cnt + 6'h01;
                st_next.ones = st_reg.ones + 6'(din);
            end
        end else begin
            st_next.tick = st_reg.tick + 18'h00001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.level;

    bypassFollow_a: assert property (@(posedge clk) disable iff (!rstn)
        (windowMs == 5'h00) |=> (dout == $past(din)))
        else $error("debounce bypass does not follow input");
endmodule : hrs_debounce

// ==== verilog/hrs_mode_decode.sv ====
`timescale 1ns/10ps
`include "hrs_defs.svh"

// Classifies the homing mode code into the inputs it needs
module hrs_mode_decode
    import hrs_pkg::*;
(
    input wire logic [7:0] code,
    output hrs_mode_t mode
);
    function automatic logic inRange(input logic [7:0] c, input logic [7:0] lo,
                                     input logic [7:0] hi);
        inRange = (c >= lo) && (c <= hi);
    endfunction : inRange

    // -----------------------------------------------------------
    // Decode
    // -----------------------------------------------------------
    always_comb begin
        mode = '0;
        if (inRange(code, `HRS_M_SW_LO, `HRS_M_SW_HI)) begin
            mode.useSwitch = 1'b1;
        end else if (inRange(code, `HRS_M_SZ_LO, `HRS_M_SZ_HI)) begin
            mode.useSwitch = 1'b1;
            mode.usePulse = 1'b1;
        end else if (inRange(code, `HRS_M_LIM_LO, `HRS_M_LIM_HI)) begin
            mode.useLimit = 1'b1;
        end else if (code == `HRS_M_HERE) begin
            mode.here = 1'b1;
        end else if (inRange(code, `HRS_M_BLK_LO, `HRS_M_BLK_HI)) begin
            mode.useBlock = 1'b1;
        end else if (code == `HRS_M_Z1 || code == `HRS_M_Z2 ||
                     inRange(code, `HRS_M_ZX_HI - 8'h01, `HRS_M_ZX_HI)) begin
            mode.usePulse = 1'b1; // limit switch plus zero pulse
            mode.useLimit = 1'b1;
        end else if (code == `HRS_M_Z33 || code == `HRS_M_Z34 ||
                     inRange(code, `HRS_M_ZX_LO, `HRS_M_ZX_LO + 8'h01)) begin
            mode.usePulse = 1'b1; // zero pulse alone
        end
        mode.valid = mode.useSwitch | mode.useLimit | mode.here | mode.useBlock |
                     mode.usePulse;
    end
endmodule : hrs_mode_decode

// ==== tb/hrs_axis_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------
// Axis model: switches and zero pulse
// ----------------------------------------
module hrs_axis_model
    import hrs_pkg::*;
(
    input wire logic clk,
    input wire hrs_motion_t motion,
    output logic homeSwPin,
    output logic limPosPin,
    output logic limNegPin,
    output logic zeroPulsePin,
    output logic curThrPin
);
    int pos = 0;

    // One step per clock while running; clamp stands in for the hard stop
    always @(posedge clk) begin
        if (motion.gotoZero === 1'b1) begin
            pos <= 0;
        end else if (motion.run === 1'b1 && motion.dirPos === 1'b1 && pos < 120) begin
            pos <= pos + 1;
        end else if (motion.run === 1'b1 && motion.dirPos !== 1'b1 && pos > -120) begin
            pos <= pos - 1;
        end
    end

    // Levels follow position; zero pulse once per 16 steps like one turn
    assign homeSwPin = (pos >= 40);
    assign limPosPin = (pos >= 100);
    assign limNegPin = (pos <= -100);
    assign zeroPulsePin = (pos[3:0] == 4'h0);
    assign curThrPin = limPosPin | limNegPin;
endmodule : hrs_axis_model

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`include "hrs_defs.svh"

// ----------------------------------------
// Bench top
// ----------------------------------------
module tb
    import hrs_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, homeSwPin, limPosPin, limNegPin, zeroPulsePin, curThrPin;
    logic absValid = 1'b1;
    logic [15:0] angleMoved = 16'h0000;
    logic referencedOutput;
    logic [31:0] zeroOffset;
    hrs_motion_t motion;
    int errors = 0;
    int n_tests = 0;
    int gotoCnt = 0;
    int runCnt = 0;
    int limBad = 0;
    int zeroCnt = 0;
    int r0;
    logic [7:0] modes [7] = '{8'h03, 8'h11, 8'h14, 8'h21, 8'h80, 8'h82, 8'h01};

    always #2.5 clk = ~clk;

    // Power-on configuration with absolute feedback and multiturn emulation enabled
    hrs_homing_sequencer #(.CFG_RESET(32'h0000_0e00)) hrs_homing_sequencer_inst (.clk(clk),
        .rstn(rstn),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .homeSwPin(homeSwPin), .limPosPin(limPosPin), .limNegPin(limNegPin),
        .zeroPulsePin(zeroPulsePin), .curThrPin(curThrPin), .absValid(absValid),
        .angleMoved(angleMoved), .motion(motion), .zeroOffset(zeroOffset),
        .referencedOutput(referencedOutput));

    hrs_axis_model hrs_axis_model_inst (.clk(clk), .motion(motion),
        .homeSwPin(homeSwPin), .limPosPin(limPosPin), .limNegPin(limNegPin),
        .zeroPulsePin(zeroPulsePin), .curThrPin(curThrPin));

    // Motion monitors; limits must stay off whenever the axis runs
    always @(posedge clk) begin
        if (motion.gotoZero === 1'b1) gotoCnt++;
        if (motion.run === 1'b1) runCnt++;
        if (motion.setZero === 1'b1) zeroCnt++;
        if (motion.run === 1'b1 && motion.limitsOff !== 1'b1) limBad++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk

    // Single AHB-Lite transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus

    task automatic cfg_w(input logic [7:0] m, input logic [31:0] extra);
        bus(1'b1, `HRS_OFF_CFG, 32'h0000_0200 | extra | {24'h0, m});
    endtask : cfg_w

    // Start a run and wait a bounded time for the referenced flag
    task automatic run_home();
        int k;
        bus(1'b1, `HRS_OFF_CTRL, 32'h0000_0001);
        for (k = 0; k < 3000 && referencedOutput !== 1'b1; k++) @(posedge clk);
        chk({31'h0, referencedOutput}, 32'h1);
    endtask : run_home

    // Reset for two cycles with new feedback levels, then read the status
    task automatic power_cycle(input logic av, input logic [15:0] am);
        @(posedge clk);
        rstn <= 1'b0;
        absValid <= av;
        angleMoved <= am;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, `HRS_OFF_STAT, 32'h0);
    endtask : power_cycle

    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        // Far beyond the few hundred cycles the tests need, under 100k cycles
        #400000;
        errors++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, `HRS_OFF_CFG, 32'h0);
        chk(rd, 32'h0000_0e00);
        chk({31'h0, hresp}, 32'h0);
        bus(1'b0, `HRS_OFF_STAT, 32'h0);
        chk(rd, 32'h0000_1008);
        bus(1'b0, 12'h0f0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `HRS_OFF_OFFSET, 32'h0000_1234);
        bus(1'b0, `HRS_OFF_OFFSET, 32'h0);
        chk(rd, 32'h0000_1234);
        chk(zeroOffset, 32'h0000_1234);
        cfg_w(`HRS_M_HERE, 32'h0);
        bus(1'b0, `HRS_OFF_STAT, 32'h0);
        chk(rd & 32'h0000_1008, 32'h0000_0008);
        r0 = runCnt;
        zeroCnt = 0;
        run_home();
        chk(32'(runCnt - r0), 32'h0);
        chk(32'(zeroCnt), 32'h1);
        bus(1'b0, `HRS_OFF_STAT, 32'h0);
        chk(rd, 32'h0000_1000);
        cfg_w(`HRS_M_HERE, 32'h0);
        @(negedge clk);
        chk({31'h0, referencedOutput}, 32'h0);
        // Each family of mode codes except here must home and approach zero once
        foreach (modes[i]) begin
            gotoCnt = 0;
            zeroCnt = 0;
            cfg_w(modes[i], 32'h0);
            run_home();
            chk(32'(gotoCnt), 32'h1);
            chk(32'(zeroCnt), 32'h1);
        end
        chk(32'(limBad), 32'h0);
        gotoCnt = 0;
        cfg_w(`HRS_M_SW_LO, 32'h0000_0100);
        run_home();
        chk(32'(gotoCnt), 32'h0);
        cfg_w(`HRS_M_NONE, 32'h0);
        @(negedge clk);
        chk({31'h0, referencedOutput}, 32'h0);
        // Power cycles: motor moved beyond the window, then stayed inside it
        power_cycle(1'b0, 16'h0001);
        chk(rd, 32'h0000_000c);
        power_cycle(1'b0, 16'h0000);
        chk(rd, 32'h0000_1008);
        tally_and_finish();
    end
endmodule : tb
